// File: logic/scm_mul_shift.sv
// signed multiply with arithmetic right shift of the full product
`timescale 1ns/10ps
module scm_mul_shift
   import scm_pkg::*;
(
   input wire logic signed [SCM_MW-1:0] opA,
   input wire logic signed [SCM_MW-1:0] opB,
   input wire logic [4:0] shift,
   output logic signed [SCM_WW-1:0] product
);
   logic signed [2*SCM_MW-1:0] full;
   logic signed [2*SCM_MW-1:0] shifted;
   assign full = opA * opB;
   // full precision kept until after the shift, so no bits are lost early
   assign shifted = full >>> shift;
   assign product = {{(SCM_WW-2*SCM_MW){shifted[2*SCM_MW-1]}}, shifted};
endmodule

// File: logic/scm_pkg.sv
// constants, codes and step states for the sensor correction datapath
package scm_pkg;
   localparam int SCM_CW = 24;
   localparam int SCM_MW = 27;
   localparam int SCM_WW = 56;
   localparam logic [7:0] SCM_CMD_CORR_LO = 8'hAA;
   localparam logic [7:0] SCM_CMD_CORR_HI = 8'hAF;
   localparam logic [7:0] SCM_CMD_RAW_STORED = 8'hA2;
   localparam logic [7:0] SCM_CMD_SEL_PRI = 8'hB0;
   localparam logic [7:0] SCM_CMD_SEL_SEC = 8'hB1;
   localparam logic [7:0] SCM_ADDR_PRI_SETUP = 8'h12;
   localparam logic [7:0] SCM_ADDR_SEC_SETUP = 8'h16;
   localparam logic [15:0] SCM_SETUP_RST = 16'h0000;
   localparam logic [4:0] SCM_SH21 = 5'h15;
   localparam logic [4:0] SCM_SH23 = 5'h17;
   localparam int SCM_STAT_SAT = 0;
   localparam logic signed [SCM_WW-1:0] SCM_HI25 = 56'sh00000001FFFFFF;
   localparam logic signed [SCM_WW-1:0] SCM_LO25 = 56'shFFFFFFFE000000;
   localparam logic signed [SCM_WW-1:0] SCM_HI24 = 56'sh00000000FFFFFF;
   localparam logic signed [SCM_WW-1:0] SCM_ONE23 = 56'sh00000000800000;
   localparam logic signed [SCM_WW-1:0] SCM_ZERO = 56'sh00000000000000;
   typedef enum logic [2:0] {
      SCM_DST_NONE = 3'b000,
      SCM_DST_ACC = 3'b001,
      SCM_DST_K1 = 3'b010,
      SCM_DST_Z = 3'b011,
      SCM_DST_SENS = 3'b100,
      SCM_DST_TEMP = 3'b101
   } scm_dst_t;
   typedef enum logic [4:0] {
      SCM_IDLE = 5'b00000,
      SCM_WAIT_RAW = 5'b00001,
      SCM_K1A = 5'b00010,
      SCM_K1B = 5'b00011,
      SCM_K1C = 5'b00100,
      SCM_K1D = 5'b00101,
      SCM_K2A = 5'b00110,
      SCM_K2B = 5'b00111,
      SCM_K2C = 5'b01000,
      SCM_K2D = 5'b01001,
      SCM_K2E = 5'b01010,
      SCM_ZA = 5'b01011,
      SCM_ZB = 5'b01100,
      SCM_ZC = 5'b01101,
      SCM_SA = 5'b01110,
      SCM_SB = 5'b01111,
      SCM_SC = 5'b10000,
      SCM_SD = 5'b10001,
      SCM_TA = 5'b10010,
      SCM_TB = 5'b10011,
      SCM_TC = 5'b10100,
      SCM_TD = 5'b10101,
      SCM_TE = 5'b10110,
      SCM_TF = 5'b10111,
      SCM_TG = 5'b11000,
      SCM_DONE = 5'b11001
   } scm_state_t;
endpackage

// File: logic/scm_sat.sv
// clamp of a wide signed value to a bound pair with overflow flag
`timescale 1ns/10ps
module scm_sat
   import scm_pkg::*;
(
   input wire logic signed [SCM_WW-1:0] value,
   input wire logic signed [SCM_WW-1:0] lower,
   input wire logic signed [SCM_WW-1:0] upper,
   output logic signed [SCM_MW-1:0] clamped,
   output logic hit
);
   logic signed [SCM_WW-1:0] bound;
   always_comb begin
      bound = value;
      hit = 1'b0;
      if (value > upper) begin
         bound = upper;
         hit = 1'b1;
      end else if (value < lower) begin
         bound = lower;
         hit = 1'b1;
      end
   end
   // the bound itself is carried on, the step is never aborted
   assign clamped = bound[SCM_MW-1:0];
endmodule

// File: logic/sensor_correction_math.sv
// correction datapath: command decode, setup select and stepwise math
`timescale 1ns/10ps
module sensor_correction_math
   import scm_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmdValid,
   input wire logic [7:0] cmdCode,
   output logic busy,
   input wire logic memWrEn,
   input wire logic [7:0] memAddr,
   input wire logic [15:0] memWrData,
   output logic measStart,
   output logic [15:0] activeSetup,
   input wire logic rawValid,
   input wire logic signed [SCM_CW-1:0] rawSensor,
   input wire logic signed [SCM_CW-1:0] rawTemp,
   input wire logic curveSelect,
   input wire logic altCoefValid,
   input wire logic signed [SCM_CW-1:0] gainS,
   input wire logic signed [SCM_CW-1:0] offsetS,
   input wire logic signed [SCM_CW-1:0] gainDrift,
   input wire logic signed [SCM_CW-1:0] offsetDrift,
   input wire logic signed [SCM_CW-1:0] secondOrderGainDrift,
   input wire logic signed [SCM_CW-1:0] secondOrderOffsetDrift,
   input wire logic signed [SCM_CW-1:0] secondOrderSensorCoefficient,
   input wire logic signed [SCM_CW-1:0] gainT,
   input wire logic signed [SCM_CW-1:0] offsetT,
   input wire logic signed [SCM_CW-1:0] secondOrderTemperatureCoefficient,
   input wire logic signed [SCM_CW-1:0] sensorShift,
   input wire logic signed [SCM_CW-1:0] tempShift,
   output logic resultValid,
   output logic [23:0] sensorOut,
   output logic [23:0] tempOut,
   output logic [7:0] statusOut
);
   scm_state_t state_r, state_nxt;
   scm_dst_t dst;
   logic [15:0] primarySetup_r, secondarySetup_r, activeSetup_r;
   logic secSel_r, rawMode_r, passMode_r, curve_r, satFlag_r;
   logic signed [SCM_CW-1:0] sRaw_r, tRaw_r;
   logic signed [SCM_MW-1:0] acc_r, k1_r, z_r, absZ, mA, mB, stepVal;
   logic [23:0] sensor_r, temp_r;
   logic [4:0] mSh;
   logic signed [SCM_WW-1:0] prod, sumA, sumB, stepSum, lo, hi;
   logic stepSat, accept, isCorr, isRaw;

   assign isCorr = (cmdCode >= SCM_CMD_CORR_LO) && (cmdCode <= SCM_CMD_CORR_HI);
   assign isRaw = (cmdCode == SCM_CMD_RAW_STORED);
   assign accept = cmdValid && (state_r == SCM_IDLE);
   assign busy = (state_r != SCM_IDLE);
   assign resultValid = (state_r == SCM_DONE);
   assign measStart = accept && (isCorr || isRaw);
   assign activeSetup = activeSetup_r;
   assign sensorOut = sensor_r;
   assign tempOut = temp_r;
   assign statusOut = {7'h00, satFlag_r};
   assign absZ = z_r[SCM_MW-1] ? -z_r : z_r;

   // setup registers written through the nonvolatile memory port
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         primarySetup_r <= SCM_SETUP_RST;
         secondarySetup_r <= SCM_SETUP_RST;
      end else if (memWrEn) begin
         if (memAddr == SCM_ADDR_PRI_SETUP) begin
            primarySetup_r <= memWrData;
         end
         if (memAddr == SCM_ADDR_SEC_SETUP) begin
            secondarySetup_r <= memWrData;
         end
      end
   end

   // selection lives only in volatile state, so every reset drops it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         secSel_r <= 1'b0;
      end else if (accept && cmdCode == SCM_CMD_SEL_SEC) begin
         secSel_r <= 1'b1;
      end else if (accept && cmdCode == SCM_CMD_SEL_PRI) begin
         secSel_r <= 1'b0;
      end
   end

   // analog setup handed to the front end with each measurement
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         activeSetup_r <= SCM_SETUP_RST;
      end else if (measStart) begin
         if (isRaw || !secSel_r) begin
            activeSetup_r <= primarySetup_r;
         end else begin
            activeSetup_r <= secondarySetup_r;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rawMode_r <= 1'b0;
         passMode_r <= 1'b0;
         curve_r <= 1'b0;
      end else if (measStart) begin
         rawMode_r <= isRaw;
         passMode_r <= secSel_r && !altCoefValid;
         curve_r <= curveSelect;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sRaw_r <= '0;
         tRaw_r <= '0;
      end else if (state_r == SCM_WAIT_RAW && rawValid) begin
         sRaw_r <= rawSensor;
         tRaw_r <= rawTemp;
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SCM_IDLE: begin
            if (measStart) begin
               state_nxt = SCM_WAIT_RAW;
            end
         end
         SCM_WAIT_RAW: begin
            if (rawValid) begin
               if (rawMode_r) begin
                  state_nxt = SCM_DONE;
               end else if (passMode_r) begin
                  state_nxt = SCM_TA;
               end else begin
                  state_nxt = SCM_K1A;
               end
            end
         end
         SCM_DONE: state_nxt = SCM_IDLE;
         SCM_K1A, SCM_K1B, SCM_K1C, SCM_K1D, SCM_K2A, SCM_K2B, SCM_K2C, SCM_K2D,
         SCM_K2E, SCM_ZA, SCM_ZB, SCM_ZC, SCM_SA, SCM_SB, SCM_SC, SCM_SD, SCM_TA,
         SCM_TB, SCM_TC, SCM_TD, SCM_TE, SCM_TF, SCM_TG: begin
            state_nxt = scm_state_t'(state_r + 5'h01);
         end
         default: state_nxt = SCM_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= SCM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // one multiply and one clamp per step; slow but small
   always_comb begin
      mA = '0;
      mB = '0;
      mSh = SCM_SH21;
      sumA = SCM_ZERO;
      sumB = SCM_ZERO;
      lo = SCM_LO25;
      hi = SCM_HI25;
      dst = SCM_DST_NONE;
      unique case (state_r)
         SCM_K1A, SCM_K2A: begin
            mA = (state_r == SCM_K1A) ? SCM_MW'(secondOrderGainDrift) :
               SCM_MW'(secondOrderOffsetDrift);
            mB = SCM_MW'(tRaw_r);
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_K1B, SCM_K2B: begin
            sumA = SCM_WW'(acc_r);
            sumB = (state_r == SCM_K1B) ? (SCM_WW'(gainDrift) <<< 2) :
               (SCM_WW'(offsetDrift) <<< 2);
            dst = SCM_DST_ACC;
         end
         SCM_K1C, SCM_K2C: begin
            mA = SCM_MW'(tRaw_r);
            mB = acc_r;
            mSh = SCM_SH23;
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_K1D: begin
            sumA = SCM_WW'(acc_r);
            sumB = SCM_ONE23;
            dst = SCM_DST_K1;
         end
         SCM_K2D: begin
            sumA = SCM_WW'(acc_r);
            sumB = SCM_WW'(sRaw_r);
            dst = SCM_DST_ACC;
         end
         SCM_K2E: begin
            sumA = SCM_WW'(acc_r);
            sumB = SCM_WW'(offsetS) <<< 2;
            dst = SCM_DST_ACC;
         end
         SCM_ZA: begin
            mA = k1_r;
            mB = acc_r;
            mSh = SCM_SH23;
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_ZB, SCM_TB: begin
            mA = (state_r == SCM_ZB) ? SCM_MW'(gainS) : SCM_MW'(gainT);
            mB = acc_r;
            sumA = prod;
            dst = SCM_DST_Z;
         end
         SCM_ZC: begin
            sumA = SCM_WW'(z_r);
            sumB = curve_r ? SCM_ZERO : SCM_ONE23;
            lo = curve_r ? SCM_LO25 : SCM_ZERO;
            dst = SCM_DST_Z;
         end
         SCM_SA: begin
            mA = SCM_MW'(secondOrderSensorCoefficient);
            mB = curve_r ? absZ : z_r;
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_SB, SCM_TE: begin
            sumA = SCM_WW'(acc_r);
            sumB = SCM_ONE23;
            dst = SCM_DST_ACC;
         end
         SCM_SC, SCM_TF: begin
            mA = z_r;
            mB = acc_r;
            mSh = SCM_SH23;
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_SD: begin
            sumA = SCM_WW'(acc_r) + (curve_r ? SCM_ONE23 : SCM_ZERO);
            sumB = SCM_WW'(sensorShift);
            lo = SCM_ZERO;
            hi = SCM_HI24;
            dst = SCM_DST_SENS;
         end
         SCM_TA: begin
            sumA = SCM_WW'(tRaw_r);
            sumB = SCM_WW'(offsetT) <<< 2;
            dst = SCM_DST_ACC;
         end
         SCM_TC: begin
            sumA = SCM_WW'(z_r);
            sumB = SCM_ONE23;
            lo = SCM_ZERO;
            dst = SCM_DST_Z;
         end
         SCM_TD: begin
            mA = SCM_MW'(secondOrderTemperatureCoefficient);
            mB = z_r;
            sumA = prod;
            dst = SCM_DST_ACC;
         end
         SCM_TG: begin
            sumA = SCM_WW'(acc_r);
            sumB = SCM_WW'(tempShift);
            lo = SCM_ZERO;
            hi = SCM_HI24;
            dst = SCM_DST_TEMP;
         end
         SCM_IDLE, SCM_WAIT_RAW, SCM_DONE: begin
            dst = SCM_DST_NONE;
         end
         default: dst = SCM_DST_NONE;
      endcase
   end

   assign stepSum = sumA + sumB;

   scm_mul_shift uMul (
      .opA(mA),
      .opB(mB),
      .shift(mSh),
      .product(prod)
   );

   scm_sat uSat (
      .value(stepSum),
      .lower(lo),
      .upper(hi),
      .clamped(stepVal),
      .hit(stepSat)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= '0;
         k1_r <= '0;
         z_r <= '0;
      end else begin
         if (dst == SCM_DST_ACC) begin
            acc_r <= stepVal;
         end
         if (dst == SCM_DST_K1) begin
            k1_r <= stepVal;
         end
         if (dst == SCM_DST_Z) begin
            z_r <= stepVal;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sensor_r <= 24'h000000;
         temp_r <= 24'h000000;
      end else begin
         if (state_r == SCM_WAIT_RAW && rawValid && (rawMode_r || passMode_r)) begin
            sensor_r <= rawSensor;
         end else if (dst == SCM_DST_SENS) begin
            sensor_r <= stepVal[23:0];
         end
         if (dst == SCM_DST_TEMP) begin
            temp_r <= stepVal[23:0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         satFlag_r <= 1'b0;
      end else if (measStart) begin
         satFlag_r <= 1'b0;
      end else if (dst != SCM_DST_NONE && stepSat) begin
         satFlag_r <= 1'b1;
      end
   end

   sequence s_computeRun;
      state_r == SCM_WAIT_RAW && rawValid && !rawMode_r && !passMode_r;
   endsequence

   sequence s_resultOut;
      resultValid && busy;
   endsequence

   a_select_second: assert property (@(posedge clk) disable iff (!arst_n)
      accept && cmdCode == SCM_CMD_SEL_SEC |=> secSel_r && !busy)
      else $error("secondary setup not selected after B1");
   a_select_first: assert property (@(posedge clk) disable iff (!arst_n)
      secSel_r && accept && cmdCode == SCM_CMD_SEL_PRI |=> !secSel_r)
      else $error("primary setup not selected after B0");
   a_corr_start: assert property (@(posedge clk) disable iff (!arst_n)
      accept && isCorr |-> measStart ##1 (state_r == SCM_WAIT_RAW))
      else $error("corrected command did not start a measurement");
   a_setup_choice: assert property (@(posedge clk) disable iff (!arst_n)
      measStart |=> activeSetup == ($past(isRaw) || !$past(secSel_r) ?
         $past(primarySetup_r) : $past(secondarySetup_r)))
      else $error("wrong analog setup handed out");
   a_flag_cleared: assert property (@(posedge clk) disable iff (!arst_n)
      measStart |=> !statusOut[SCM_STAT_SAT])
      else $error("saturation flag not cleared at start");
   a_sat_cause: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(satFlag_r) |-> $past(stepSat) && $past(dst) != SCM_DST_NONE)
      else $error("saturation flag set without a clamp");
   a_calc_length: assert property (@(posedge clk) disable iff (!arst_n)
      s_computeRun |-> ##24 s_resultOut)
      else $error("corrected result not ready after 24 cycles");
   a_pass_through: assert property (@(posedge clk) disable iff (!arst_n)
      resultValid && passMode_r |-> sensorOut == sRaw_r[23:0])
      else $error("pass-through output differs from raw value");
   a_zp_positive: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == SCM_SA && !curve_r |-> !z_r[SCM_MW-1])
      else $error("parabolic Z below zero");
   a_zt_positive: assert property (@(posedge clk) disable iff (!arst_n)
      state_r == SCM_TD |-> !z_r[SCM_MW-1] && z_r <= SCM_MW'(SCM_HI25))
      else $error("temperature Z outside positive range");
endmodule

// File: sim/scm_frontend_model.sv
// front end model that answers each measurement request with one raw pair
`timescale 1ns/10ps
module scm_frontend_model
   import scm_pkg::*;
#(
   parameter int DLY = 3
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic measStart,
   input wire logic signed [SCM_CW-1:0] sVal,
   input wire logic signed [SCM_CW-1:0] tVal,
   output logic rawValid,
   output logic signed [SCM_CW-1:0] rawSensor,
   output logic signed [SCM_CW-1:0] rawTemp
);
   int cnt;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         rawValid <= 1'b0;
         rawSensor <= '0;
         rawTemp <= '0;
      end else begin
         rawValid <= 1'b0;
         // lines toggle outside a transfer so a stale value never looks right
         rawSensor <= ~rawSensor;
         rawTemp <= ~rawTemp;
         if (measStart) begin
            cnt <= DLY;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (cnt == 1 && !measStart) begin
            rawValid <= 1'b1;
            rawSensor <= sVal;
            rawTemp <= tVal;
         end
      end
   end
endmodule

// File: sim/sensor_correction_math_tb.sv
// scenario testbench for the sensor correction datapath
`timescale 1ns/10ps
module sensor_correction_math_tb
   import scm_pkg::*;
;
   logic clk, arst_n, cmdValid, busy, memWrEn, measStart, rawValid;
   logic curveSelect, altCoefValid, resultValid;
   logic [7:0] cmdCode, memAddr, statusOut;
   logic [15:0] memWrData, activeSetup;
   logic [23:0] sensorOut, tempOut;
   logic signed [SCM_CW-1:0] rawSensor, rawTemp, sVal, tVal, gainS, offsetS;
   logic signed [SCM_CW-1:0] gainDrift, offsetDrift, secondOrderGainDrift;
   logic signed [SCM_CW-1:0] secondOrderOffsetDrift, secondOrderSensorCoefficient;
   logic signed [SCM_CW-1:0] gainT, offsetT, secondOrderTemperatureCoefficient;
   logic signed [SCM_CW-1:0] sensorShift, tempShift;
   int n_errors = 0;
   int comparisons = 0;

   sensor_correction_math sensor_correction_math_i (
      .clk(clk),
      .arst_n(arst_n),
      .cmdValid(cmdValid),
      .cmdCode(cmdCode),
      .busy(busy),
      .memWrEn(memWrEn),
      .memAddr(memAddr),
      .memWrData(memWrData),
      .measStart(measStart),
      .activeSetup(activeSetup),
      .rawValid(rawValid),
      .rawSensor(rawSensor),
      .rawTemp(rawTemp),
      .curveSelect(curveSelect),
      .altCoefValid(altCoefValid),
      .gainS(gainS),
      .offsetS(offsetS),
      .gainDrift(gainDrift),
      .offsetDrift(offsetDrift),
      .secondOrderGainDrift(secondOrderGainDrift),
      .secondOrderOffsetDrift(secondOrderOffsetDrift),
      .secondOrderSensorCoefficient(secondOrderSensorCoefficient),
      .gainT(gainT),
      .offsetT(offsetT),
      .secondOrderTemperatureCoefficient(secondOrderTemperatureCoefficient),
      .sensorShift(sensorShift),
      .tempShift(tempShift),
      .resultValid(resultValid),
      .sensorOut(sensorOut),
      .tempOut(tempOut),
      .statusOut(statusOut)
   );
   scm_frontend_model #(.DLY(3)) scm_frontend_model_i (
      .clk(clk),
      .arst_n(arst_n),
      .measStart(measStart),
      .sVal(sVal),
      .tVal(tVal),
      .rawValid(rawValid),
      .rawSensor(rawSensor),
      .rawTemp(rawTemp)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic finish_test();
      $display("comparisons %0d, errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] code);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdCode <= code;
      @(posedge clk);
      cmdValid <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      memWrEn <= 1'b1;
      memAddr <= a;
      memWrData <= d;
      @(posedge clk);
      memWrEn <= 1'b0;
   endtask

   task automatic setups();
      wr(8'h12, 16'hA5A5);
      wr(8'h16, 16'h5A5A);
      // unmapped address must leave both setups alone
      wr(8'h13, 16'hFFFF);
   endtask

   task automatic meas(input logic [7:0] code, input logic [23:0] eS, input logic [23:0] eT,
                       input logic [7:0] eSt, input logic [15:0] eSet);
      int i;
      cmd(code);
      for (i = 0; i < 80 && resultValid !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (resultValid !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: no result for code %h", $time, code);
         finish_test();
      end
      chk(sensorOut, eS, "sensor result");
      chk(tempOut, eT, "temperature result");
      chk({16'h0000, statusOut}, {16'h0000, eSt}, "status byte");
      chk({8'h00, activeSetup}, {8'h00, eSet}, "active setup");
      // later stimulus changes land just after a rising edge
      @(posedge clk);
   endtask

   initial begin
      arst_n = 1'b0;
      cmdValid = 1'b0;
      cmdCode = 8'h00;
      memWrEn = 1'b0;
      memAddr = 8'h00;
      memWrData = 16'h0000;
      curveSelect = 1'b0;
      altCoefValid = 1'b0;
      sVal = 24'sh00ABCD;
      tVal = 24'sh001000;
      gainS = 24'sh200000;
      offsetS = 24'sh000100;
      gainDrift = 24'sh000000;
      offsetDrift = 24'sh000000;
      secondOrderGainDrift = 24'sh000000;
      secondOrderOffsetDrift = 24'sh000000;
      secondOrderSensorCoefficient = 24'sh000000;
      gainT = 24'sh200000;
      offsetT = 24'sh000010;
      secondOrderTemperatureCoefficient = 24'sh000000;
      sensorShift = 24'sh000000;
      tempShift = 24'sh000000;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      cmd(8'h55);
      @(negedge clk);
      chk({23'h000000, busy}, 24'h000000, "unknown code starts nothing");
      setups();
      meas(8'hA2, 24'h00ABCD, 24'h000000, 8'h00, 16'hA5A5);
      sVal <= -24'sh010000;
      meas(8'hAB, 24'h7F0400, 24'h801040, 8'h00, 16'hA5A5);
      sensorShift <= -24'sh000010;
      tempShift <= 24'sh000020;
      meas(8'hAC, 24'h7F03F0, 24'h801060, 8'h00, 16'hA5A5);
      sensorShift <= 24'sh000000;
      secondOrderSensorCoefficient <= 24'sh200000;
      sVal <= 24'sh000000;
      // parabolic lifts this to 2^24 + 0xC00, just past the output range
      meas(8'hAD, 24'hFFFFFF, 24'h801060, 8'h01, 16'hA5A5);
      curveSelect <= 1'b1;
      sVal <= 24'sh040000;
      meas(8'hAE, 24'h842440, 24'h801060, 8'h00, 16'hA5A5);
      cmd(8'hB1);
      sVal <= 24'sh012345;
      meas(8'hAF, 24'h012345, 24'h801060, 8'h00, 16'h5A5A);
      cmd(8'hB0);
      curveSelect <= 1'b0;
      secondOrderSensorCoefficient <= 24'sh000000;
      meas(8'hAA, 24'h812745, 24'h801060, 8'h00, 16'hA5A5);
      cmd(8'hB1);
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      chk(sensorOut, 24'h000000, "sensor output after reset");
      setups();
      meas(8'hAB, 24'h812745, 24'h801060, 8'h00, 16'hA5A5);
      cmd(8'hB1);
      // secondary setup with valid coefficients runs the full correction
      altCoefValid <= 1'b1;
      meas(8'hAB, 24'h812745, 24'h801060, 8'h00, 16'h5A5A);
      finish_test();
   end
endmodule
